// [hw/ths_regs.svh]
// register offsets, field positions and reset values of the high-temperature stamp block
`ifndef THS_REGS_SVH
`define THS_REGS_SVH

// stamp registers are word indexes; the byte address is four times the index
`define THS_IDX_HOURS     6'h22
`define THS_IDX_DATE      6'h23
`define THS_OFF_HOURS     {`THS_IDX_HOURS, 2'b00}
`define THS_OFF_DATE      {`THS_IDX_DATE, 2'b00}
`define THS_OFF_CTRL      8'h40
`define THS_OFF_IRQ_STAT  8'h44
`define THS_OFF_IRQ_MASK  8'h48

`define THS_STAMP_RESET   8'h00
`define THS_STAMP_MSB     5
`define THS_CTRL_EN_BIT   0
`define THS_CTRL_OW_BIT   1
`define THS_CTRL_CLR_BIT  2
`define THS_CTRL_RESET    2'h0
`define THS_IRQ_CAP_BIT   0
`define THS_IRQ_CLR_BIT   1
`define THS_IRQ_W         2

`define THS_RESP_OKAY     2'h0
`define THS_RESP_SLVERR   2'h2

`endif

// [hw/ths_pkg.sv]
// types of the high-temperature stamp block
package ths_pkg;

  typedef enum logic [1:0] {
    THS_W_IDLE = 2'b00,
    THS_W_RESP = 2'b01
  } ths_wstate_type;

  typedef struct packed {
    logic [7:0]     hours;
    logic [7:0]     date;
    logic           enable;
    logic           overwrite;
    logic           have_stamp;
    logic [1:0]     irq_stat;
    logic [1:0]     irq_mask;
    logic           irq;
    ths_wstate_type wstate;
    logic           awready;
    logic           wready;
    logic           aw_held;
    logic [7:0]     aw_addr;
    logic           w_held;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } ths_state_type;

endpackage

// [hw/ths_stamp.sv]
// high-temperature event stamp of hours and date, with an axi4-lite register slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ths_regs.svh"

module ths_stamp
  import ths_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        temp_high_event,
  input  wire logic [5:0]  cal_hours,
  input  wire logic [5:0]  cal_date,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       temp_high_stamp_hours,
  output logic [7:0]       temp_high_stamp_date,
  output logic             irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a[7:2] == `THS_OFF_CTRL >> 2) || (a[7:2] == `THS_OFF_IRQ_STAT >> 2) ||
                 (a[7:2] == `THS_OFF_IRQ_MASK >> 2) || (a == `THS_OFF_HOURS) ||
                 (a == `THS_OFF_DATE);
  endfunction

  ths_state_type state_r;
  ths_state_type state_nxt;
  logic          capture;
  logic          clear_req;
  logic          do_write;
  logic [7:0]    rd_addr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    do_write  = 1'b0;
    clear_req = 1'b0;
    rd_addr   = s_axi_araddr;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && state_r.awready) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = s_axi_awaddr;
      state_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && state_r.wready) begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = s_axi_wdata;
      state_nxt.w_strb = s_axi_wstrb;
      state_nxt.wready = 1'b0;
    end
    case (state_r.wstate)
      THS_W_IDLE: begin
        if (state_r.aw_held && state_r.w_held) begin
          do_write          = 1'b1;
          state_nxt.aw_held = 1'b0;
          state_nxt.w_held  = 1'b0;
          state_nxt.bvalid  = 1'b1;
          state_nxt.bresp   = addr_known(state_r.aw_addr) ? `THS_RESP_OKAY : `THS_RESP_SLVERR;
          state_nxt.wstate  = THS_W_RESP;
        end
      end
      THS_W_RESP: begin
        if (s_axi_bready) begin
          state_nxt.bvalid  = 1'b0;
          state_nxt.awready = 1'b1;
          state_nxt.wready  = 1'b1;
          state_nxt.wstate  = THS_W_IDLE;
        end
      end
      default: state_nxt.wstate = THS_W_IDLE;
    endcase

    // register writes; stamp offsets fall through untouched
    if (do_write && state_r.w_strb[0]) begin
      if (state_r.aw_addr[7:2] == `THS_OFF_CTRL >> 2) begin
        state_nxt.enable    = state_r.w_data[`THS_CTRL_EN_BIT];
        state_nxt.overwrite = state_r.w_data[`THS_CTRL_OW_BIT];
        clear_req           = state_r.w_data[`THS_CTRL_CLR_BIT];
      end else if (state_r.aw_addr[7:2] == `THS_OFF_IRQ_MASK >> 2) begin
        state_nxt.irq_mask = state_r.w_data[`THS_IRQ_W-1:0];
      end
    end

    // capture and clear; clear at the same cycle as a capture lets the capture win
    capture = temp_high_event && state_r.enable &&
              (state_r.overwrite || !state_r.have_stamp);
    if (clear_req) begin
      state_nxt.hours      = `THS_STAMP_RESET;
      state_nxt.date       = `THS_STAMP_RESET;
      state_nxt.have_stamp = 1'b0;
      state_nxt.irq_stat[`THS_IRQ_CLR_BIT] = 1'b1;
    end
    if (capture) begin
      state_nxt.hours      = {2'b00, cal_hours};
      state_nxt.date       = {2'b00, cal_date};
      state_nxt.have_stamp = 1'b1;
    end

    // read channel, one cycle answer
    if (s_axi_arvalid && state_r.arready) begin
      state_nxt.arready = 1'b0;
      state_nxt.rvalid  = 1'b1;
      state_nxt.rresp   = `THS_RESP_OKAY;
      state_nxt.rdata   = 32'h0000_0000;
      if (rd_addr == `THS_OFF_HOURS) begin
        state_nxt.rdata[7:0] = {2'b00, state_r.hours[`THS_STAMP_MSB:0]};
      end else if (rd_addr == `THS_OFF_DATE) begin
        state_nxt.rdata[7:0] = {2'b00, state_r.date[`THS_STAMP_MSB:0]};
      end else if (rd_addr[7:2] == `THS_OFF_CTRL >> 2) begin
        state_nxt.rdata[`THS_CTRL_EN_BIT] = state_r.enable;
        state_nxt.rdata[`THS_CTRL_OW_BIT] = state_r.overwrite;
      end else if (rd_addr[7:2] == `THS_OFF_IRQ_STAT >> 2) begin
        state_nxt.rdata[`THS_IRQ_W-1:0] = state_r.irq_stat;
        state_nxt.irq_stat = 2'b00;
        if (clear_req) begin
          state_nxt.irq_stat[`THS_IRQ_CLR_BIT] = 1'b1;
        end
      end else if (rd_addr[7:2] == `THS_OFF_IRQ_MASK >> 2) begin
        state_nxt.rdata[`THS_IRQ_W-1:0] = state_r.irq_mask;
      end else begin
        state_nxt.rresp = `THS_RESP_SLVERR;
      end
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid  = 1'b0;
      state_nxt.arready = 1'b1;
    end
    if (capture) begin
      state_nxt.irq_stat[`THS_IRQ_CAP_BIT] = 1'b1;
    end
    state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r           <= '0;
      state_r.hours     <= `THS_STAMP_RESET;
      state_r.date      <= `THS_STAMP_RESET;
      state_r.wstate    <= THS_W_IDLE;
      state_r.awready   <= 1'b1;
      state_r.wready    <= 1'b1;
      state_r.arready   <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready         = state_r.awready;
  assign s_axi_wready          = state_r.wready;
  assign s_axi_bvalid          = state_r.bvalid;
  assign s_axi_bresp           = state_r.bresp;
  assign s_axi_arready         = state_r.arready;
  assign s_axi_rvalid          = state_r.rvalid;
  assign s_axi_rdata           = state_r.rdata;
  assign s_axi_rresp           = state_r.rresp;
  assign temp_high_stamp_hours = state_r.hours;
  assign temp_high_stamp_date  = state_r.date;
  assign irq                   = state_r.irq;

endmodule

`default_nettype wire

// [tb/ths_stamp_sva.sv]
// port assertions of the high-temperature stamp block
`timescale 1ns/1ns
`default_nettype none
module ths_stamp_sva (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       temp_high_event,
  input wire logic [5:0] cal_hours,
  input wire logic [5:0] cal_date,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic [7:0] temp_high_stamp_hours,
  input wire logic [7:0] temp_high_stamp_date
);
  // ------------------------------------------
  // stamp and read-channel properties
  // ------------------------------------------
  wire logic [7:0] sh = temp_high_stamp_hours;
  wire logic [7:0] sd = temp_high_stamp_date;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_top; sh[7:6] == 2'b00 && sd[7:6] == 2'b00; endproperty
  a_top: assert property (p_top) else $error("stamp top bits set");
  property p_range; sh <= 8'h23 && sd <= 8'h31; endproperty
  a_range: assert property (p_range) else $error("stamp out of range");
  property p_hcap; $changed(sh) && sh != 8'h00 |-> $past(temp_high_event) && sh[5:0] == $past(cal_hours); endproperty
  a_hcap: assert property (p_hcap) else $error("hours stamp not the live hours");
  property p_dcap; $changed(sd) && sd != 8'h00 |-> $past(temp_high_event) && sd[5:0] == $past(cal_date); endproperty
  a_dcap: assert property (p_dcap) else $error("date stamp not the live date");
  property p_cause; $changed({sh, sd}) |-> $past(temp_high_event) || $rose(s_axi_bvalid); endproperty
  a_cause: assert property (p_cause) else $error("stamp moved without cause");
  property p_clr; $changed({sh, sd}) && !$past(temp_high_event) |-> {sh, sd} == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("clear left a nonzero stamp");
  property p_pair; sd == 8'h00 |-> sh == 8'h00; endproperty
  a_pair: assert property (p_pair) else $error("date zero with hours set");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_cap: cover property ($past(temp_high_event) && $changed(sh));
  c_clr: cover property ($changed(sd) && sd == 8'h00);
  c_rd: cover property (s_axi_rvalid);
endmodule
bind ths_stamp ths_stamp_sva u_sva (.*);
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the high-temperature stamp block
`timescale 1ns/1ns
`default_nettype none
`include "ths_regs.svh"
module testbench;
  logic        core_clk = 1'b0, resetn = 1'b0, temp_high_event = 1'b0;
  logic [5:0]  cal_hours = 6'h00, cal_date = 6'h00;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  temp_high_stamp_hours, temp_high_stamp_date;
  int          miscompares = 0, checks_done = 0;
  ths_stamp dut (.*);
  always #20 core_clk = ~core_clk;
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  function automatic logic [5:0] bcd(input int v);
    return {2'(v / 10), 4'(v % 10)};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ev(input int h, input int d);
    @(posedge core_clk);
    temp_high_event <= 1'b1;
    cal_hours <= bcd(h);
    cal_date <= bcd(d);
    @(posedge core_clk);
    temp_high_event <= 1'b0;
    cal_hours <= bcd((h + 7) % 24);
    cal_date <= bcd(d % 31 + 1);
    @(posedge core_clk);
  endtask
  task automatic both(input int h, input int d);
    chk(temp_high_stamp_hours, {2'b00, bcd(h)}, "hours port");
    chk(temp_high_stamp_date, {2'b00, bcd(d)}, "date port");
    rdr(`THS_OFF_HOURS);
    chk(rd, {26'h0, bcd(h)}, "hours reg");
    rdr(`THS_OFF_DATE);
    chk(rd, {26'h0, bcd(d)}, "date reg");
  endtask
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  initial begin
    int h, d;
    void'($urandom(32'hfb1d));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    both(0, 0);
    wr(`THS_OFF_IRQ_MASK, 32'h1);
    wr(`THS_OFF_CTRL, 32'h1);
    ev(23, 31);
    both(23, 31);
    chk(irq, 1'b1, "irq raised");
    rdr(`THS_OFF_IRQ_STAT);
    chk(rd[0], 1'b1, "capture status");
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0, "irq cleared");
    ev($urandom % 24, $urandom % 31 + 1);
    both(23, 31);
    wr(`THS_OFF_HOURS, 32'hff);
    chk(rsp, `THS_RESP_OKAY, "write resp");
    wr(`THS_OFF_DATE, 32'h3f);
    both(23, 31);
    rdr(8'h30);
    chk(rd, 32'h0, "unmapped read data");
    chk(rsp, `THS_RESP_SLVERR, "unmapped read resp");
    wr(`THS_OFF_CTRL, 32'h3);
    repeat (4) begin
      h = $urandom % 24;
      d = $urandom % 31 + 1;
      ev(h, d);
      both(h, d);
    end
    wr(`THS_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0, "irq masked");
    wr(`THS_OFF_CTRL, 32'h4);
    both(0, 0);
    ev(5, 9);
    both(0, 0);
    wr(`THS_OFF_CTRL, 32'h1);
    ev(7, 12);
    both(7, 12);
    conclude();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
